// file: design/gtu_map.svh
// Register indices, field positions, reset values and timing figures of the timer unit
`ifndef GTU_MAP_SVH
`define GTU_MAP_SVH
`define GTU_AW 5
`define GTU_A_MODCFG 5'h00
`define GTU_A_PORT_DATA 5'h01
`define GTU_A_PORT_DIR 5'h02
`define GTU_A_FREE_COUNT 5'h03
`define GTU_A_ACCUM_CTL 5'h04
`define GTU_A_ACCUM_COUNT 5'h05
`define GTU_A_CAPTURE0 5'h06
`define GTU_A_COMPARE0 5'h09
`define GTU_A_CH5 5'h0d
`define GTU_A_ACTION 5'h0e
`define GTU_A_EDGE 5'h0f
`define GTU_A_CLOCK_SEL 5'h10
`define GTU_A_FLAGS 5'h11
`define GTU_A_PWM_CTL 5'h12
`define GTU_A_DUTY_A 5'h13
`define GTU_A_DUTY_B 5'h14
`define GTU_A_PWM_COUNT 5'h15
`define GTU_A_PRESCALE 5'h16
`define GTU_MODCFG_PRIV 15
`define GTU_AC_GCLK 0
`define GTU_AC_DIR5 2
`define GTU_AC_PINLVL 3
`define GTU_AC_EDGE 4
`define GTU_AC_MODE 5
`define GTU_AC_EN 6
`define GTU_FLG_IC 0
`define GTU_FLG_OC 3
`define GTU_FLG_CH5 7
`define GTU_FLG_CWRAP 8
`define GTU_FLG_AWRAP 9
`define GTU_FLG_AIN 10
`define GTU_PWM_SLOW 0
`define GTU_PWM_CLK 2
`define GTU_CC_RST 16'hffff
`define GTU_EXT_SEL 3'h7
`define GTU_DIV512 9'h1ff
`define GTU_GC_DIV512 2'h0
`define GTU_GC_COUNT 2'h1
`define GTU_GC_WRAP 2'h2
`endif

// file: design/gtu_pkg.sv
// Types shared by the timer unit modules
package gtu_pkg;
	typedef struct packed {
		logic priv_select;
		logic [7:0] port_data;
		logic [7:0] port_dir;
		logic [15:0] shared_free_count;
		logic [1:0] gated_clock_sel;
		logic fifth_channel_dir_sel;
		logic accum_edge_sel;
		logic accum_mode_sel;
		logic accum_en;
		logic [7:0] accum_count;
		logic [2:0][15:0] capture;
		logic [3:0][15:0] compare;
		logic [15:0] ch5;
		logic [9:0] compare_action;
		logic [7:0] capture_edge;
		logic [2:0] count_clock_sel;
		logic [10:0] flags;
		logic [4:0] oc_level;
		logic [2:0] pwm_clock_sel;
		logic [1:0] pwm_slow;
		logic [7:0] duty_a;
		logic [7:0] duty_b;
		logic [15:0] pwm_count;
		logic [8:0] presc;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic [7:0] pin_s3;
		logic [2:0] ext_s;
		logic [2:0] acc_s;
		logic [15:0] rdata;
	} gtu_state_t;
	typedef struct packed {
		logic out;
	} gtu_pwm_state_t;
endpackage

// file: design/gtu_pwm_if.sv
// Signals between the timer core and one PWM channel
`timescale 1ns/1ps
interface gtu_pwm_if;
	logic [15:0] cnt;
	logic [7:0] duty;
	logic slow;
	logic out;
	modport ctl (output cnt, output duty, output slow, input out);
	modport chan (input cnt, input duty, input slow, output out);
endinterface

// file: design/gtu_pwm.sv
// One PWM output channel compared against the shared PWM counter
`timescale 1ns/1ps
module gtu_pwm
	import gtu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	gtu_pwm_if.chan pw
);
	gtu_pwm_state_t st_r;
	gtu_pwm_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		// Slow mode uses the upper byte, so the period is 256 times longer
		if (pw.slow)
			st_nxt.out = (pw.cnt[15:8] < pw.duty);
		else
			st_nxt.out = (pw.cnt[7:0] < pw.duty);
		if (sys_rst)
			st_nxt = '0;
	end

	always_ff @(posedge clk)
	begin
		st_r <= st_nxt;
	end

	assign pw.out = st_r.out;
endmodule // gtu_pwm

// file: design/gtu_top.sv
// Timer unit: capture/compare, pulse accumulator, PWM and register port
//
// Functional notes
// - Three capture, four compare channels and one channel selectable either way.
// - All capture and compare channels share one 16-bit free-running counter.
// - Shared counter ticks from a nine-stage prescaler tap or the external clock pin.
// - Accumulator holds an 8-bit counter with event and gated modes.
// - Mode select 0 counts external events, 1 accumulates gated time.
// - Event mode counts falling edges when edge select is 0, rising when 1.
// - Gated mode stops while the pin is low (select 0) or high (select 1).
// - Gated clock 00 is clock/512, 01 the counter clock, 10 counter wrap.
// - Fifth channel select 0 makes it compare, 1 makes it capture.
// - A read-only bit returns the current external clock pin level.
// - Two PWM outputs share one counter, each with its own duty value.
// - Each PWM channel runs in fast or slow mode independently.
// - PWM has its own 16-bit counter from a prescaler tap or external clock.
// - Capture/compare pins form an 8-bit two-way port; PWM out, others in.
// - Module config is supervisor only; the other registers follow the privilege select bit.
// - Counter clock codes 000-110 divide by 4 to 256; 111 uses the external pin.
// - Counter wrap flag sets at FFFF to 0000; accumulator flag at FF to 00.
// - Compare action 00 disconnects, 01 toggles, 10 clears, 11 sets the pin.
// - Capture edge 00 disables, 01 rising, 10 falling, 11 either edge.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "gtu_map.svh"
module gtu_top
	import gtu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_privilege_select,
	output logic [15:0] reg_rdata,
	input wire logic [7:0] timer_pin_in,
	output logic [7:0] timer_pin_out,
	output logic [7:0] timer_pin_oe,
	input wire logic accum_input_pin,
	input wire logic ext_clock_pin,
	output logic pwm_a,
	output logic pwm_b
);
	gtu_state_t st_r;
	gtu_state_t st_nxt;
	gtu_pwm_if pwa ();
	gtu_pwm_if pwb ();

	// Prescaler tap tick: code n divides by 2^(n+2); code 111 handled by caller
	function automatic logic tap_tick(input logic [8:0] p, input logic [2:0] sel);
		logic [8:0] mask;
		mask = (9'h004 << sel) - 9'h001;
		return ((p & mask) == mask);
	endfunction

	function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] md);
		case (md)
			2'h1: return (!prev && cur);
			2'h2: return (prev && !cur);
			2'h3: return (prev != cur);
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic act_level(input logic lvl, input logic [1:0] act);
		case (act)
			2'h1: return !lvl;
			2'h2: return 1'b0;
			2'h3: return 1'b1;
			default: return lvl;
		endcase
	endfunction

	// Word index inside the capture or compare bank
	function automatic logic [1:0] cc_slot(input logic [4:0] a, input logic [4:0] base);
		logic [4:0] d;
		d = a - base;
		return d[1:0];
	endfunction

	// Module config is supervisor only; the rest follow the privilege select bit
	function automatic logic reg_permit(input logic [4:0] a, input logic sv, input logic pv);
		return sv || ((a != `GTU_A_MODCFG) && !pv);
	endfunction

	logic ext_tick;
	logic cnt_tick;
	logic pwm_tick;
	logic div512_tick;
	logic cnt_wrap;
	logic acc_inc;
	logic acc_edge;
	logic acc_gate;
	logic gate_clk;
	logic acc_ok;
	logic rd_ok;
	logic wr_ok;
	logic gate_prev;
	logic [4:0] oc_drive;
	logic [10:0] flag_nxt;
	logic [7:0] pin_cap;
	logic [3:0] oc_match;
	logic ch5_match;
	logic [10:0] flag_set;
	logic [15:0] rd_val;
	logic [16:0] cnt_sum;

	// Sampled pin levels only come from the second and third sync stages
	assign ext_tick = st_r.ext_s[1] && !st_r.ext_s[2];
	assign div512_tick = (st_r.presc == `GTU_DIV512);
	assign cnt_tick = (st_r.count_clock_sel == `GTU_EXT_SEL) ? ext_tick
		: tap_tick(st_r.presc, st_r.count_clock_sel);
	assign pwm_tick = (st_r.pwm_clock_sel == `GTU_EXT_SEL) ? ext_tick
		: tap_tick(st_r.presc, st_r.pwm_clock_sel);
	assign cnt_sum = {1'b0, st_r.shared_free_count} + 17'h00001;
	assign cnt_wrap = cnt_tick && cnt_sum[16];

	// A compare matches in the tick that brings the counter onto its value
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			oc_match[i] = cnt_tick && (cnt_sum[15:0] == st_r.compare[i]);
		ch5_match = cnt_tick && (cnt_sum[15:0] == st_r.ch5) && !st_r.fifth_channel_dir_sel;
		for (int i = 0; i < 8; i++)
			pin_cap[i] = 1'b0;
		for (int i = 0; i < 3; i++)
			pin_cap[i] = edge_hit(st_r.pin_s3[i], st_r.pin_s2[i],
				st_r.capture_edge[2*i +: 2]);
		pin_cap[7] = st_r.fifth_channel_dir_sel
			&& edge_hit(st_r.pin_s3[7], st_r.pin_s2[7], st_r.capture_edge[7:6]);
	end

	// Gated mode: count while the pin is away from its inhibit level
	assign acc_gate = st_r.acc_s[1] ^ st_r.accum_edge_sel;
	assign gate_prev = st_r.acc_s[2] ^ st_r.accum_edge_sel;
	assign acc_edge = st_r.accum_edge_sel ? (st_r.acc_s[1] && !st_r.acc_s[2])
		: (!st_r.acc_s[1] && st_r.acc_s[2]);
	always_comb
	begin
		case (st_r.gated_clock_sel)
			`GTU_GC_DIV512: gate_clk = div512_tick;
			`GTU_GC_COUNT: gate_clk = cnt_tick;
			`GTU_GC_WRAP: gate_clk = cnt_wrap;
			default: gate_clk = 1'b0;
		endcase
	end
	assign acc_inc = st_r.accum_en && (st_r.accum_mode_sel ? (gate_clk && acc_gate)
		: acc_edge);

	always_comb
	begin
		flag_set = '0;
		flag_set[`GTU_FLG_IC +: 3] = pin_cap[2:0];
		flag_set[`GTU_FLG_OC +: 4] = oc_match;
		flag_set[`GTU_FLG_CH5] = ch5_match || pin_cap[7];
		flag_set[`GTU_FLG_CWRAP] = cnt_wrap;
		flag_set[`GTU_FLG_AWRAP] = acc_inc && (st_r.accum_count == 8'hff);
		// Gated period ends when the pin enters its inhibit level
		flag_set[`GTU_FLG_AIN] = st_r.accum_en
			&& (st_r.accum_mode_sel ? (!acc_gate && gate_prev) : acc_edge);
	end

	// Flags clear on a written one; a same-cycle event still sets the bit
	always_comb
	begin
		flag_nxt = st_r.flags;
		if (wr_ok && (reg_addr == `GTU_A_FLAGS))
			flag_nxt = st_r.flags & ~reg_wdata[10:0];
		flag_nxt = flag_nxt | flag_set;
	end

	// A refused access reads zero and writes nothing
	assign acc_ok = reg_permit(reg_addr, reg_privilege_select, st_r.priv_select);
	assign rd_ok = reg_rd && acc_ok;
	assign wr_ok = reg_wr && acc_ok;

	always_comb
	begin
		rd_val = '0;
		case (reg_addr)
			`GTU_A_MODCFG: rd_val[`GTU_MODCFG_PRIV] = st_r.priv_select;
			`GTU_A_PORT_DATA: rd_val[7:0] = (st_r.port_dir & st_r.port_data)
				| (~st_r.port_dir & st_r.pin_s2);
			`GTU_A_PORT_DIR: rd_val[7:0] = st_r.port_dir;
			`GTU_A_FREE_COUNT: rd_val = st_r.shared_free_count;
			`GTU_A_ACCUM_CTL:
			begin
				rd_val[`GTU_AC_GCLK +: 2] = st_r.gated_clock_sel;
				rd_val[`GTU_AC_DIR5] = st_r.fifth_channel_dir_sel;
				rd_val[`GTU_AC_PINLVL] = st_r.ext_s[1];
				rd_val[`GTU_AC_EDGE] = st_r.accum_edge_sel;
				rd_val[`GTU_AC_MODE] = st_r.accum_mode_sel;
				rd_val[`GTU_AC_EN] = st_r.accum_en;
			end
			`GTU_A_ACCUM_COUNT: rd_val[7:0] = st_r.accum_count;
			5'h06, 5'h07, 5'h08:
				rd_val = st_r.capture[cc_slot(reg_addr, `GTU_A_CAPTURE0)];
			5'h09, 5'h0a, 5'h0b, 5'h0c:
				rd_val = st_r.compare[cc_slot(reg_addr, `GTU_A_COMPARE0)];
			`GTU_A_CH5: rd_val = st_r.ch5;
			`GTU_A_ACTION: rd_val[9:0] = st_r.compare_action;
			`GTU_A_EDGE: rd_val[7:0] = st_r.capture_edge;
			`GTU_A_CLOCK_SEL: rd_val[2:0] = st_r.count_clock_sel;
			`GTU_A_FLAGS: rd_val[10:0] = st_r.flags;
			`GTU_A_PWM_CTL:
			begin
				rd_val[`GTU_PWM_SLOW +: 2] = st_r.pwm_slow;
				rd_val[`GTU_PWM_CLK +: 3] = st_r.pwm_clock_sel;
			end
			`GTU_A_DUTY_A: rd_val[7:0] = st_r.duty_a;
			`GTU_A_DUTY_B: rd_val[7:0] = st_r.duty_b;
			`GTU_A_PWM_COUNT: rd_val = st_r.pwm_count;
			`GTU_A_PRESCALE: rd_val[8:0] = st_r.presc;
			default: rd_val = '0;
		endcase
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pin_s1 = timer_pin_in;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_s3 = st_r.pin_s2;
		st_nxt.ext_s = {st_r.ext_s[1:0], ext_clock_pin};
		st_nxt.acc_s = {st_r.acc_s[1:0], accum_input_pin};
		// Both counters tap this one prescaler, so their ticks stay in step
		st_nxt.presc = st_r.presc + 9'h001;
		st_nxt.rdata = '0;
		if (cnt_tick)
			st_nxt.shared_free_count = cnt_sum[15:0];
		if (pwm_tick)
			st_nxt.pwm_count = st_r.pwm_count + 16'h0001;
		if (acc_inc)
			st_nxt.accum_count = st_r.accum_count + 8'h01;
		for (int i = 0; i < 3; i++)
			if (pin_cap[i])
				st_nxt.capture[i] = st_r.shared_free_count;
		if (pin_cap[7])
			st_nxt.ch5 = st_r.shared_free_count;
		for (int i = 0; i < 4; i++)
			if (oc_match[i])
				st_nxt.oc_level[i] = act_level(st_r.oc_level[i],
					st_r.compare_action[2*i +: 2]);
		if (ch5_match)
			st_nxt.oc_level[4] = act_level(st_r.oc_level[4], st_r.compare_action[9:8]);
		if (rd_ok)
			st_nxt.rdata = rd_val;
		if (wr_ok)
		begin
			case (reg_addr)
				`GTU_A_MODCFG: st_nxt.priv_select = reg_wdata[`GTU_MODCFG_PRIV];
				`GTU_A_PORT_DATA: st_nxt.port_data = reg_wdata[7:0];
				`GTU_A_PORT_DIR: st_nxt.port_dir = reg_wdata[7:0];
				`GTU_A_ACCUM_CTL:
				begin
					st_nxt.gated_clock_sel = reg_wdata[`GTU_AC_GCLK +: 2];
					st_nxt.fifth_channel_dir_sel = reg_wdata[`GTU_AC_DIR5];
					st_nxt.accum_edge_sel = reg_wdata[`GTU_AC_EDGE];
					st_nxt.accum_mode_sel = reg_wdata[`GTU_AC_MODE];
					st_nxt.accum_en = reg_wdata[`GTU_AC_EN];
				end
				`GTU_A_ACCUM_COUNT: st_nxt.accum_count = reg_wdata[7:0];
				5'h09, 5'h0a, 5'h0b, 5'h0c:
					st_nxt.compare[cc_slot(reg_addr, `GTU_A_COMPARE0)] = reg_wdata;
				`GTU_A_CH5: st_nxt.ch5 = reg_wdata;
				`GTU_A_ACTION: st_nxt.compare_action = reg_wdata[9:0];
				`GTU_A_EDGE: st_nxt.capture_edge = reg_wdata[7:0];
				`GTU_A_CLOCK_SEL: st_nxt.count_clock_sel = reg_wdata[2:0];
				`GTU_A_PWM_CTL:
				begin
					st_nxt.pwm_slow = reg_wdata[`GTU_PWM_SLOW +: 2];
					st_nxt.pwm_clock_sel = reg_wdata[`GTU_PWM_CLK +: 3];
				end
				`GTU_A_DUTY_A: st_nxt.duty_a = reg_wdata[7:0];
				`GTU_A_DUTY_B: st_nxt.duty_b = reg_wdata[7:0];
				default: st_nxt.rdata = st_nxt.rdata;
			endcase
		end
		st_nxt.flags = flag_nxt;
		// Capture and compare banks reset to all ones so no early match fires
		if (sys_rst)
		begin
			st_nxt = '0;
			st_nxt.capture = {3{`GTU_CC_RST}};
			st_nxt.compare = {4{`GTU_CC_RST}};
			st_nxt.ch5 = `GTU_CC_RST;
		end
	end

	always_ff @(posedge clk)
	begin
		st_r <= st_nxt;
	end

	// A compare channel owns its pin whenever its action is not disconnect
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			oc_drive[i] = (st_r.compare_action[2*i +: 2] != 2'h0);
		oc_drive[4] = !st_r.fifth_channel_dir_sel && (st_r.compare_action[9:8] != 2'h0);
	end

	// Pins: a connected compare action overrides the port, otherwise port data and direction
	always_comb
	begin
		timer_pin_out = st_r.port_data;
		timer_pin_oe = st_r.port_dir;
		for (int i = 0; i < 4; i++)
			if (oc_drive[i])
			begin
				timer_pin_out[3+i] = st_r.oc_level[i];
				timer_pin_oe[3+i] = 1'b1;
			end
		if (oc_drive[4])
		begin
			timer_pin_out[7] = st_r.oc_level[4];
			timer_pin_oe[7] = 1'b1;
		end
	end

	assign reg_rdata = st_r.rdata;

	// Both channels see the same counter, so they share one frequency when their slow bits match
	assign pwa.cnt = st_r.pwm_count;
	assign pwa.duty = st_r.duty_a;
	assign pwa.slow = st_r.pwm_slow[0];
	assign pwb.cnt = st_r.pwm_count;
	assign pwb.duty = st_r.duty_b;
	assign pwb.slow = st_r.pwm_slow[1];

	gtu_pwm u_pwm_a (
		.clk(clk),
		.sys_rst(sys_rst),
		.pw(pwa.chan)
	);

	gtu_pwm u_pwm_b (
		.clk(clk),
		.sys_rst(sys_rst),
		.pw(pwb.chan)
	);

	// PWM pins are output only
	assign pwm_a = pwa.out;
	assign pwm_b = pwb.out;
endmodule // gtu_top

// file: bench/gtu_pin_model.sv
// Model of the outside world at the timer pins
`timescale 1ns/1ps
module gtu_pin_model (
	input wire logic clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	output logic [7:0] pin_in,
	output logic acc_pin,
	output logic ext_pin
);
	// Bits 7:0 timer pins, 8 accumulator input, 9 external clock
	logic [9:0] lvl_r = 10'h000;
	// Device drive wins where enabled, else the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl_r[7:0]);
	assign acc_pin = lvl_r[8];
	assign ext_pin = lvl_r[9];
	// Settles past the three-stage synchroniser before returning
	task automatic set_in(input int i, input logic v);
		@(posedge clk);
		lvl_r[i] <= v;
		repeat (5) @(posedge clk);
	endtask
	task automatic ext_pulse(input int n);
		repeat (n)
		begin
			set_in(9, 1'b1);
			set_in(9, 1'b0);
		end
	endtask
endmodule // gtu_pin_model

// file: bench/gtu_top_sva.sv
// Port checker for the timer unit
`timescale 1ns/1ps
module gtu_top_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_privilege_select,
	input wire logic [15:0] reg_rdata,
	input wire logic [7:0] timer_pin_in,
	input wire logic [7:0] timer_pin_out,
	input wire logic [7:0] timer_pin_oe,
	input wire logic accum_input_pin,
	input wire logic ext_clock_pin,
	input wire logic pwm_a,
	input wire logic pwm_b
);
	// Shadows of the few fields the assertions need, fed by permitted writes only
	logic priv_r, ext_q;
	logic [2:0] csel_r, stab_r;
	logic [6:0] actl_r;
	logic [9:0] act_r;
	logic [7:0] dir_r, duty_r;
	logic [1:0] dz_r;
	wire wok = reg_wr && (reg_privilege_select || (reg_addr != 5'h00 && !priv_r));
	wire [3:0] cmp_on = {|act_r[7:6], |act_r[5:4], |act_r[3:2], |act_r[1:0]};
	always_ff @(posedge clk)
	begin
		priv_r <= sys_rst ? 1'b0 : (wok && reg_addr == 5'h00) ? reg_wdata[15] : priv_r;
		csel_r <= sys_rst ? 3'h0 : (wok && reg_addr == 5'h10) ? reg_wdata[2:0] : csel_r;
		actl_r <= sys_rst ? 7'h00 : (wok && reg_addr == 5'h04) ? reg_wdata[6:0] : actl_r;
		act_r <= sys_rst ? 10'h000 : (wok && reg_addr == 5'h0e) ? reg_wdata[9:0] : act_r;
		dir_r <= sys_rst ? 8'h00 : (wok && reg_addr == 5'h02) ? reg_wdata[7:0] : dir_r;
		duty_r <= sys_rst ? 8'h00 : (wok && reg_addr == 5'h13) ? reg_wdata[7:0] : duty_r;
		dz_r <= (sys_rst || duty_r != 8'h00) ? 2'h0 : (dz_r == 2'h3 ? dz_r : dz_r + 2'h1);
		ext_q <= ext_clock_pin;
		stab_r <= (sys_rst || ext_clock_pin != ext_q) ? 3'h0 :
			(stab_r == 3'h7 ? stab_r : stab_r + 3'h1);
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence presc_rd;
		reg_rd && reg_privilege_select && reg_addr == 5'h16;
	endsequence
	cfg_guard_a: assert property (reg_rd && !reg_privilege_select && reg_addr == 5'h00 |=>
		reg_rdata == 16'h0000) else $error("user read of config not blocked");
	priv_guard_a: assert property (reg_rd && !reg_privilege_select && priv_r |=>
		reg_rdata == 16'h0000) else $error("user read not blocked");
	pin_level_a: assert property (reg_rd && reg_privilege_select && reg_addr == 5'h04 && stab_r > 3'h3
		|=> reg_rdata[3] == $past(ext_clock_pin)) else $error("pin level bit wrong");
	presc_step_a: assert property (presc_rd ##2 presc_rd |=>
		reg_rdata[8:0] == $past(reg_rdata[8:0], 2) + 9'h002) else $error("prescaler step");
	count_div4_a: assert property ((reg_rd && reg_privilege_select && reg_addr == 5'h03 && csel_r == 3'h0)
		##4 (reg_rd && reg_privilege_select && reg_addr == 5'h03) |=> reg_rdata == $past(reg_rdata, 4)
		+ 16'h0001) else $error("count rate wrong");
	hold_gate_a: assert property ((reg_rd && reg_privilege_select && reg_addr == 5'h05 && actl_r[5] &&
		actl_r[1:0] == 2'h3) ##8 (reg_rd && reg_privilege_select && reg_addr == 5'h05) |=>
		reg_rdata == $past(reg_rdata, 8)) else $error("reserved gate clock counted");
	cmp_drive_a: assert property (dir_r[6:0] == 7'h00 |-> timer_pin_oe[6:0] == {cmp_on, 3'h0})
		else $error("compare pin drive wrong");
	pwm_zero_a: assert property (dz_r == 2'h3 |-> !pwm_a)
		else $error("zero duty output high");
	rst_quiet_a: assert property ($fell(sys_rst) |-> reg_rdata == 16'h0000 &&
		timer_pin_oe == 8'h00 && !pwm_a && !pwm_b) else $error("outputs not quiet at reset");
	cover property (presc_rd ##2 presc_rd);
	cover property (reg_rd && !reg_privilege_select && priv_r);
	cover property (actl_r[5] && reg_rd && reg_addr == 5'h05);
endmodule // gtu_top_chk
bind gtu_top gtu_top_chk chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_privilege_select, .reg_rdata, .timer_pin_in, .timer_pin_out, .timer_pin_oe, .accum_input_pin,
	.ext_clock_pin, .pwm_a, .pwm_b);

// file: bench/tb_top.sv
// Self-checking bench for the timer unit
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_privilege_select = 1'b1;
	logic [15:0] reg_rdata, v0, v1, d;
	logic [7:0] pin_in, pin_out, pin_oe;
	logic acc_pin, ext_pin, pwm_a, pwm_b;
	int n_fail = 0;
	int tests_run = 0;
	int na, nb;
	logic [15:0] gctl [5] = '{16'h0060, 16'h0060, 16'h0070, 16'h0061, 16'h0063};
	int gn [5] = '{512, 512, 512, 4, 8};
	always #20 clk = ~clk;
	gtu_top dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_privilege_select, .reg_rdata,
		.timer_pin_in(pin_in), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe),
		.accum_input_pin(acc_pin), .ext_clock_pin(ext_pin), .pwm_a, .pwm_b);
	gtu_pin_model pm (.clk, .pin_out, .pin_oe, .pin_in, .acc_pin, .ext_pin);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] w, input logic s = 1'b1);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_privilege_select <= s;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe, so it is taken just past that edge
	task automatic rd(input logic [4:0] a, output logic [15:0] v, input logic s = 1'b1);
		@(posedge clk);
		reg_addr <= a;
		reg_privilege_select <= s;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] e, input logic s = 1'b1);
		logic [15:0] v;
		rd(a, v, s);
		chk(v, e);
	endtask
	// Two reads exactly n cycles apart; n of 2 or more
	task automatic dr(input logic [4:0] a, input int n, output logic [15:0] df);
		rd(a, v0);
		repeat (n - 2) @(posedge clk);
		rd(a, v1);
		df = v1 - v0;
	endtask
	task automatic give_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 6; i < 14; i++)
			rc(i[4:0], 16'hffff);
		for (int c = 0; c < 7; c++)
		begin
			wr(5'h10, 16'(c));
			dr(5'h03, 4 << c, d);
			chk(d, 16'h0001);
		end
		wr(5'h10, 16'h0007);
		rd(5'h03, v0);
		pm.set_in(9, 1'b1);
		rc(5'h04, 16'h0008);
		pm.set_in(9, 1'b0);
		rc(5'h04, 16'h0000);
		pm.ext_pulse(4);
		rd(5'h03, v1);
		chk(v1 - v0, 16'h0005);
		wr(5'h10, 16'h0000);
		dr(5'h16, 2, d);
		chk(d & 16'h01ff, 16'h0002);
		chk(v1 & 16'hfe00, 16'h0000);
		for (int e = 0; e < 2; e++)
		begin
			wr(5'h04, 16'h0040 | 16'(e << 4));
			wr(5'h05, 16'h0000);
			pm.set_in(8, 1'b1);
			rc(5'h05, 16'(e));
			pm.set_in(8, 1'b0);
			rc(5'h05, 16'h0001);
		end
		wr(5'h05, 16'h00ff);
		pm.set_in(8, 1'b1);
		rc(5'h05, 16'h0000);
		rd(5'h11, d);
		chk(d & 16'h0200, 16'h0200);
		wr(5'h11, 16'h0200);
		rd(5'h11, d);
		chk(d & 16'h0200, 16'h0000);
		for (int k = 0; k < 5; k++)
		begin
			wr(5'h04, gctl[k]);
			pm.set_in(8, 1'(5'h1d >> k));
			dr(5'h05, gn[k], d);
			chk(d, 16'((5'h09 >> k) & 1));
		end
		pm.set_in(8, 1'b0);
		wr(5'h04, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			wr(5'h0e, 16'(3 - k));
			rd(5'h03, d);
			wr(5'h09, d + 16'h0004);
			repeat (24) @(posedge clk);
			#1 chk(16'({pin_oe[3], pin_oe[3] & pin_out[3]}), 16'((8'h3b >> (2 * k)) & 3));
		end
		rd(5'h11, d);
		chk(d & 16'h0008, 16'h0008);
		for (int k = 0; k < 4; k++)
		begin
			wr(5'h0f, 16'(k));
			wr(5'h11, 16'h0001);
			pm.set_in(0, 1'b1);
			rd(5'h11, d);
			chk(d & 16'h0001, 16'(k & 1));
			pm.set_in(0, 1'b0);
			rd(5'h11, d);
			chk(d & 16'h0001, 16'((k | (k >> 1)) & 1));
		end
		wr(5'h04, 16'h0004);
		wr(5'h0f, 16'h0040);
		wr(5'h11, 16'h00ff);
		pm.set_in(7, 1'b1);
		rd(5'h11, d);
		chk(d & 16'h0080, 16'h0080);
		pm.set_in(7, 1'b0);
		wr(5'h04, 16'h0000);
		wr(5'h10, 16'h0001);
		wr(5'h00, 16'h8000);
		rc(5'h10, 16'h0000, 1'b0);
		rc(5'h00, 16'h0000, 1'b0);
		wr(5'h10, 16'h0003, 1'b0);
		rc(5'h10, 16'h0001);
		rc(5'h00, 16'h8000);
		wr(5'h00, 16'h0000);
		wr(5'h10, 16'h0002, 1'b0);
		rc(5'h10, 16'h0002, 1'b0);
		rc(5'h1f, 16'h0000);
		wr(5'h02, 16'h0008);
		wr(5'h01, 16'h0008);
		pm.set_in(1, 1'b1);
		rc(5'h01, 16'h000a);
		chk(16'(pin_oe), 16'h0008);
		chk(16'(pin_out & pin_oe), 16'h0008);
		pm.set_in(1, 1'b0);
		wr(5'h02, 16'h0000);
		wr(5'h12, 16'h0002);
		wr(5'h13, 16'h0080);
		wr(5'h14, 16'h00ff);
		na = 0;
		nb = 0;
		repeat (1024)
		begin
			@(posedge clk);
			#1 na += int'(pwm_a);
			nb += int'(pwm_b);
		end
		chk(16'(na), 16'h0200);
		chk(16'(nb), 16'h0400);
		wr(5'h13, 16'h0000);
		dr(5'h15, 4, d);
		chk(d, 16'h0001);
		give_verdict();
	end
endmodule // tb_top
